/* File: wice_decoder.sv */
// Wide instruction class decode and modified-immediate expansion
//
// Function
// - Treat as wide only when the major opcode is nonzero.
// - Major 01: multiple, dual/exclusive, shifted data processing, coprocessor classes.
// - Major 10 flag 0: modified or plain immediate; flag 1: branch and control.
// - Major 11: single store for 000x xx0, byte load for 00xx 001.
// - Major 11: halfword 00xx 011, word 00xx 101, undefined 00xx 111.
// - Major 11: register data, multiply, long multiply/divide, coprocessor classes.
// - Opcodes 0000x AND/test, 0001x bit clear, 0010x OR/move.
// - Opcodes 0011x OR-NOT/NOT, 0100x XOR/test-equivalence.
// - Add/compare-negative, add-carry, subtract-carry, subtract/compare, reverse subtract.
// - Unallocated modified-immediate opcodes are flagged undefined.
// - Top bits 00: zero-extend, halfword-low, halfword-high or four-fold byte pattern.
// - Replicated pattern with zero byte is unpredictable; any value allowed.
// - Otherwise rotate one-plus-seven-bit value right by immediate bits 11:7.
// - Logical ops with 00xxx keep carry; others take constant bit 31.
// - Constant never uses incoming carry; carry-out passes it for patterns.
`include "wice_map.svh"
`default_nettype none
module wice_decoder (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [15:0] i_first_half,
    input wire logic [15:0] i_second_half,
    input wire logic i_carry_in,
    output logic [3:0] o_instr_class,
    output logic [4:0] o_dp_op,
    output logic o_is_wide,
    output logic o_undefined,
    output logic o_is_logical,
    output logic o_carry_changes,
    output logic o_carry_value,
    output logic [31:0] o_imm_value
);
    import wice_pkg::*;

    wice_state_s state_ff;
    wice_state_s nxt_state;

    // Rotate right; pure function so the constant cannot see carry-in
    function automatic logic [31:0] wice_ror(input logic [31:0] val, input logic [4:0] amt);
        logic [63:0] dbl;
        dbl = {val, val} >> amt;
        return dbl[31:0];
    endfunction

    function automatic logic wice_match(input logic [6:0] val, input logic [6:0] pat,
                                        input logic [6:0] care);
        return ((val ^ pat) & care) == 7'h00;
    endfunction

    // Register field of all ones selects the alternate operation form
    function automatic logic wice_all_ones(input logic [3:0] reg_field);
        return reg_field == `WICE_REG_ALL_ONES;
    endfunction

    // Rotated form whenever the top two immediate bits are nonzero
    function automatic logic wice_is_rotated(input logic [11:0] imm);
        return imm[11:10] != 2'b00;
    endfunction

    // Byte placement for the unrotated forms
    function automatic logic [31:0] wice_byte_pattern(input logic [1:0] sel,
                                                      input logic [7:0] val);
        logic [31:0] pat;
        case (sel)
            2'b00: pat = {24'h00_0000, val};
            2'b01: pat = {8'h00, val, 8'h00, val};
            2'b10: pat = {val, 8'h00, val, 8'h00};
            default: pat = {4{val}};
        endcase
        return pat;
    endfunction

    logic [1:0] major_opcode;
    logic [6:0] secondary_opcode;
    logic second_half_flag;
    logic [3:0] first_operand_reg;
    logic [3:0] dest_reg;
    logic [2:0] mid_imm_field;
    logic [11:0] packed_twelve_bit_imm;
    logic [4:0] dp_opcode;
    logic [7:0] low_byte;
    logic [31:0] unrotated;
    logic [31:0] expanded;
    logic expand_carry;
    logic rn_all;
    logic rd_all;

    always_comb begin
        major_opcode = i_first_half[`WICE_MAJ_HI:`WICE_MAJ_LO];
        secondary_opcode = i_first_half[`WICE_SEC_HI:`WICE_SEC_LO];
        second_half_flag = i_second_half[`WICE_FLAG_BIT];
        first_operand_reg = i_first_half[`WICE_RN_HI:`WICE_RN_LO];
        dest_reg = i_second_half[`WICE_RD_HI:`WICE_RD_LO];
        mid_imm_field = i_second_half[`WICE_MID_HI:`WICE_MID_LO];
        dp_opcode = i_first_half[`WICE_DP_OP_HI:`WICE_DP_OP_LO];
        low_byte = i_second_half[7:0];
        rn_all = wice_all_ones(first_operand_reg);
        rd_all = wice_all_ones(dest_reg);
        packed_twelve_bit_imm = {i_first_half[`WICE_I_BIT], mid_imm_field, low_byte};
    end

    // imm_expand_with_carry
    always_comb begin
        unrotated = {24'h00_0000, 1'b1, packed_twelve_bit_imm[6:0]};
        if (!wice_is_rotated(packed_twelve_bit_imm)) begin
            // Zero byte on replicated forms is unpredictable; we just replicate
            expanded = wice_byte_pattern(packed_twelve_bit_imm[9:8], low_byte);
            expand_carry = i_carry_in;
        end else begin
            // Carry-out of a rotate is the top bit it lands on
            expanded = wice_ror(unrotated, packed_twelve_bit_imm[11:7]);
            expand_carry = expanded[31];
        end
    end

    always_comb begin
        nxt_state = '0;
        nxt_state.instr_class = WICE_CLS_NARROW;
        nxt_state.dp_op = WICE_OP_NONE;
        nxt_state.imm_value = expanded;
        nxt_state.is_wide = major_opcode != 2'b00;
        case (major_opcode)
            2'b01: begin
                if (secondary_opcode[6])
                    nxt_state.instr_class = WICE_CLS_COPROC;
                else if (secondary_opcode[5])
                    nxt_state.instr_class = WICE_CLS_DP_SHIFT;
                else if (secondary_opcode[2])
                    nxt_state.instr_class = WICE_CLS_LDST_DUAL;
                else
                    nxt_state.instr_class = WICE_CLS_LDST_MULTI;
            end
            2'b10: begin
                if (second_half_flag)
                    nxt_state.instr_class = WICE_CLS_BRANCH_MISC;
                else if (secondary_opcode[5])
                    nxt_state.instr_class = WICE_CLS_DP_PLAINIMM;
                else
                    nxt_state.instr_class = WICE_CLS_DP_MODIMM;
            end
            2'b11: begin
                // Wide rows first; load and store rows only once bits 6:5 are 00
                if (secondary_opcode[6])
                    nxt_state.instr_class = WICE_CLS_COPROC;
                else if (secondary_opcode[5:3] == 3'b111)
                    nxt_state.instr_class = WICE_CLS_LONG_MUL_DIV;
                else if (secondary_opcode[5:3] == 3'b110)
                    nxt_state.instr_class = WICE_CLS_MUL;
                else if (secondary_opcode[5:4] == 2'b10)
                    nxt_state.instr_class = WICE_CLS_DP_REG;
                else if (wice_match(secondary_opcode, 7'b0000000, 7'b1110001))
                    nxt_state.instr_class = WICE_CLS_STORE_SINGLE;
                else if (secondary_opcode[2:0] == 3'b001)
                    nxt_state.instr_class = WICE_CLS_LOAD_BYTE;
                else if (secondary_opcode[2:0] == 3'b011)
                    nxt_state.instr_class = WICE_CLS_LOAD_HALF;
                else if (secondary_opcode[2:0] == 3'b101)
                    nxt_state.instr_class = WICE_CLS_LOAD_WORD;
                else
                    nxt_state.instr_class = WICE_CLS_UNDEF;
            end
            default: nxt_state.instr_class = WICE_CLS_NARROW;
        endcase
        // Operation only for the modified-immediate class; others report none
        if (nxt_state.instr_class == WICE_CLS_DP_MODIMM) begin
            case (dp_opcode[4:1])
                4'h0: begin
                    nxt_state.dp_op = rd_all ? WICE_OP_TEST : WICE_OP_AND;
                    nxt_state.is_logical = 1'b1;
                end
                4'h1: begin
                    nxt_state.dp_op = WICE_OP_BITCLR;
                    nxt_state.is_logical = 1'b1;
                end
                4'h2: begin
                    nxt_state.dp_op = rn_all ? WICE_OP_MOVE : WICE_OP_OR;
                    nxt_state.is_logical = 1'b1;
                end
                4'h3: begin
                    nxt_state.dp_op = rn_all ? WICE_OP_NOT : WICE_OP_ORNOT;
                    nxt_state.is_logical = 1'b1;
                end
                4'h4: begin
                    nxt_state.dp_op = rd_all ? WICE_OP_TESTEQ : WICE_OP_XOR;
                    nxt_state.is_logical = 1'b1;
                end
                4'h8: nxt_state.dp_op = rd_all ? WICE_OP_CMPNEG : WICE_OP_ADD;
                4'ha: nxt_state.dp_op = WICE_OP_ADDC;
                4'hb: nxt_state.dp_op = WICE_OP_SUBC;
                4'hd: nxt_state.dp_op = rd_all ? WICE_OP_CMP : WICE_OP_SUB;
                4'he: nxt_state.dp_op = WICE_OP_RSUB;
                default: nxt_state.dp_op = WICE_OP_UNDEF;
            endcase
        end
        nxt_state.undefined = (nxt_state.instr_class == WICE_CLS_UNDEF)
                              || (nxt_state.dp_op == WICE_OP_UNDEF);
        // Flag-setting still gated by execute; we only say whether carry would move
        nxt_state.carry_changes = nxt_state.is_logical
                                  && wice_is_rotated(packed_twelve_bit_imm);
        nxt_state.carry_value = nxt_state.carry_changes ? expanded[31] : expand_carry;
    end

    // Registered so execute never sees a half-settled decode
    always_ff @(posedge i_ref_clk) begin
        if (i_reset)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign o_instr_class = state_ff.instr_class;
    assign o_dp_op = state_ff.dp_op;
    assign o_is_wide = state_ff.is_wide;
    assign o_undefined = state_ff.undefined;
    assign o_is_logical = state_ff.is_logical;
    assign o_carry_changes = state_ff.carry_changes;
    assign o_carry_value = state_ff.carry_value;
    assign o_imm_value = state_ff.imm_value;
endmodule
`default_nettype wire

/* File: wice_decoder_monitor.sv */
// Port-level checks for the wide instruction decoder
`default_nettype none
module wice_decoder_monitor (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [15:0] i_first_half,
    input wire logic [15:0] i_second_half,
    input wire logic i_carry_in,
    input wire logic [3:0] o_instr_class,
    input wire logic [4:0] o_dp_op,
    input wire logic o_is_wide,
    input wire logic o_undefined,
    input wire logic o_is_logical,
    input wire logic o_carry_changes,
    input wire logic o_carry_value,
    input wire logic [31:0] o_imm_value
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    logic [1:0] maj;
    logic [1:0] top;
    assign maj = i_first_half[12:11];
    assign top = {i_first_half[10], i_second_half[14]};
    narrow_path_a: assert property (maj == 2'h0 |=> o_instr_class == 4'h0 && !o_is_wide)
        else $error("narrow word decoded wide");
    modimm_class_a: assert property (maj == 2'h2 && !i_second_half[15]
        && !i_first_half[9] |=> o_instr_class == 4'h5) else $error("bad modimm class");
    mul_class_a: assert property (maj == 2'h3 && i_first_half[10:7] == 4'h6
        |=> o_instr_class == 4'hd) else $error("multiply row misclassed");
    undef_row_a: assert property (maj == 2'h3 && i_first_half[10:9] == 2'h0
        && i_first_half[6:4] == 3'h7 |=> o_undefined) else $error("undef row missed");
    undef_op_a: assert property (maj == 2'h2 && !i_second_half[15]
        && !i_first_half[9] && i_first_half[8:5] inside {4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hf}
        |=> o_dp_op == 5'h11 && o_undefined) else $error("undef op not flagged");
    zero_ext_a: assert property (top == 2'h0 && i_second_half[13:12] == 2'h0
        |=> o_imm_value == {24'h00_0000, $past(i_second_half[7:0])}) else $error("bad zero ext");
    rot_carry_a: assert property (top != 2'h0 |=> o_carry_value == o_imm_value[31])
        else $error("bad rotate carry");
    carry_keep_a: assert property (top == 2'h0 |=> !o_carry_changes)
        else $error("carry changed for pattern");
    carry_pass_a: assert property (top == 2'h0 |=> o_carry_value == $past(i_carry_in))
        else $error("carry not passed");
    cover property (o_dp_op == 5'h05);
    cover property (o_instr_class == 4'hf);
    cover property (o_carry_changes);
endmodule
bind wice_decoder wice_decoder_monitor u_mon (.*);
`default_nettype wire

/* File: wice_fetch_model.sv */
// Fetch stage model handing well-formed wide instruction halfwords
`default_nettype none
module wice_fetch_model (
    input wire logic [15:0] i_raw_first,
    input wire logic [15:0] i_raw_second,
    output logic [15:0] o_first_half,
    output logic [15:0] o_second_half
);
    logic rep;
    // Program never holds a zero replicated byte, its constant is unpredictable
    assign rep = {i_raw_first[10], i_raw_second[14:12]} inside {4'h1, 4'h2, 4'h3};
    assign o_first_half = {3'h7, i_raw_first[12:0]};
    assign o_second_half = {i_raw_second[15:8],
        (rep && i_raw_second[7:0] == 8'h00) ? 8'h5a : i_raw_second[7:0]};
endmodule
`default_nettype wire

/* File: wice_map.svh */
// Field positions and encodings for the wide instruction decoder
`ifndef WICE_MAP_SVH
`define WICE_MAP_SVH
`define WICE_REG_ALL_ONES 4'hf
`define WICE_MAJ_HI 12
`define WICE_MAJ_LO 11
`define WICE_SEC_HI 10
`define WICE_SEC_LO 4
`define WICE_FLAG_BIT 15
`define WICE_I_BIT 10
`define WICE_MID_HI 14
`define WICE_MID_LO 12
`define WICE_DP_OP_HI 8
`define WICE_DP_OP_LO 4
`define WICE_RN_HI 3
`define WICE_RN_LO 0
`define WICE_RD_HI 11
`define WICE_RD_LO 8
`endif

/* File: wice_pkg.sv */
// Types for the wide instruction decoder
`default_nettype none
package wice_pkg;
    typedef enum logic [3:0] {
        WICE_CLS_NARROW = 4'h0,
        WICE_CLS_LDST_MULTI = 4'h1,
        WICE_CLS_LDST_DUAL = 4'h2,
        WICE_CLS_DP_SHIFT = 4'h3,
        WICE_CLS_COPROC = 4'h4,
        WICE_CLS_DP_MODIMM = 4'h5,
        WICE_CLS_DP_PLAINIMM = 4'h6,
        WICE_CLS_BRANCH_MISC = 4'h7,
        WICE_CLS_STORE_SINGLE = 4'h8,
        WICE_CLS_LOAD_BYTE = 4'h9,
        WICE_CLS_LOAD_HALF = 4'ha,
        WICE_CLS_LOAD_WORD = 4'hb,
        WICE_CLS_DP_REG = 4'hc,
        WICE_CLS_MUL = 4'hd,
        WICE_CLS_LONG_MUL_DIV = 4'he,
        WICE_CLS_UNDEF = 4'hf
    } wice_class_e;
    typedef enum logic [4:0] {
        WICE_OP_NONE = 5'h00, WICE_OP_AND = 5'h01, WICE_OP_TEST = 5'h02,
        WICE_OP_BITCLR = 5'h03, WICE_OP_OR = 5'h04, WICE_OP_MOVE = 5'h05,
        WICE_OP_ORNOT = 5'h06, WICE_OP_NOT = 5'h07, WICE_OP_XOR = 5'h08,
        WICE_OP_TESTEQ = 5'h09, WICE_OP_ADD = 5'h0a, WICE_OP_CMPNEG = 5'h0b,
        WICE_OP_ADDC = 5'h0c, WICE_OP_SUBC = 5'h0d, WICE_OP_SUB = 5'h0e,
        WICE_OP_CMP = 5'h0f, WICE_OP_RSUB = 5'h10, WICE_OP_UNDEF = 5'h11
    } wice_dp_op_e;
    typedef struct packed {
        wice_class_e instr_class;
        wice_dp_op_e dp_op;
        logic is_wide;
        logic undefined;
        logic is_logical;
        logic carry_changes;
        logic carry_value;
        logic [31:0] imm_value;
    } wice_state_s;
endpackage
`default_nettype wire

/* File: wide_instr_class_and_imm_expand_tb.sv */
// Self-checking bench for the wide instruction decoder
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: output differs from model", $time); end end
module wide_instr_class_and_imm_expand_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_carry_in = 1'b0;
    logic [15:0] raw_first = 16'h0000, raw_second = 16'h0000, i_first_half, i_second_half;
    logic [3:0] o_instr_class;
    logic [4:0] o_dp_op;
    logic o_is_wide, o_undefined, o_is_logical, o_carry_changes, o_carry_value;
    logic [31:0] o_imm_value, r;
    logic [45:0] e, exp_q[$];
    int num_errors = 0, check_count = 0;
    integer seed;
    wice_fetch_model u_fetch (.i_raw_first(raw_first), .i_raw_second(raw_second),
        .o_first_half(i_first_half), .o_second_half(i_second_half));
    wice_decoder uut (.i_ref_clk, .i_reset, .i_first_half, .i_second_half, .i_carry_in,
        .o_instr_class, .o_dp_op, .o_is_wide, .o_undefined, .o_is_logical, .o_carry_changes,
        .o_carry_value, .o_imm_value);
    function automatic logic [45:0] exp_of(input logic [15:0] f, s, input logic c, rst);
        logic [6:0] sec;
        logic [11:0] imm;
        logic [63:0] rot;
        logic [31:0] k;
        logic [3:0] cls;
        logic [4:0] op;
        logic rd, rn, lg, t;
        sec = f[10:4];
        rd = s[11:8] == 4'hf;
        rn = f[3:0] == 4'hf;
        imm = {f[10], s[14:12], s[7:0]};
        t = imm[11:10] != 2'h0;
        cls = 4'h0;
        op = 5'h00;
        case (f[12:11])
            2'h1: cls = sec[6] ? 4'h4 : sec[5] ? 4'h3 : sec[2] ? 4'h2 : 4'h1;
            2'h2: cls = s[15] ? 4'h7 : sec[5] ? 4'h6 : 4'h5;
            2'h3: begin
                if (sec[6] || sec[5])
                    cls = sec[6] ? 4'h4 : !sec[4] ? 4'hc : sec[3] ? 4'he : 4'hd;
                else if (!sec[0]) cls = sec[4] ? 4'hf : 4'h8;
                else cls = (sec[2:1] == 2'h3) ? 4'hf : 4'h9 + {2'h0, sec[2:1]};
            end
            default: ;
        endcase
        if (cls == 4'h5) begin
            case (f[8:5])
                4'h0: op = rd ? 5'h02 : 5'h01;
                4'h1: op = 5'h03;
                4'h2: op = rn ? 5'h05 : 5'h04;
                4'h3: op = rn ? 5'h07 : 5'h06;
                4'h4: op = rd ? 5'h09 : 5'h08;
                4'h8: op = rd ? 5'h0b : 5'h0a;
                4'ha: op = 5'h0c;
                4'hb: op = 5'h0d;
                4'hd: op = rd ? 5'h0f : 5'h0e;
                4'he: op = 5'h10;
                default: op = 5'h11;
            endcase
        end
        case (imm[9:8])
            2'h0: k = {24'h00_0000, imm[7:0]};
            2'h1: k = {2{8'h00, imm[7:0]}};
            2'h2: k = {2{imm[7:0], 8'h00}};
            default: k = {4{imm[7:0]}};
        endcase
        rot = {2{24'h00_0000, 1'b1, imm[6:0]}} >> imm[11:7];
        if (t) k = rot[31:0];
        lg = op inside {[5'h01:5'h09]};
        exp_of = rst ? 46'h0000_0000_0000 : {cls, op, f[12:11] != 2'h0,
            cls == 4'hf || op == 5'h11, lg, lg && t, t ? k[31] : c, k};
    endfunction
    task automatic apply(input logic [15:0] f, s, input logic c, rst);
        @(negedge i_ref_clk);
        raw_first = f;
        raw_second = s;
        i_carry_in = c;
        i_reset = rst;
        @(posedge i_ref_clk);
        exp_q.push_back(exp_of(i_first_half, i_second_half, c, rst));
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    always @(negedge i_ref_clk) begin
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK(o_instr_class, e[45:42])
            `CHK({o_is_wide, o_undefined}, e[36:35])
            `CHK(o_dp_op, e[41:37])
            `CHK({o_is_logical, o_carry_changes}, e[34:33])
            `CHK(o_carry_value, e[32])
            `CHK(o_imm_value, e[31:0])
        end
    end
    initial begin
        seed = 94;
        repeat (4) apply(16'h0000, 16'h0000, 1'b0, 1'b1);
        apply(16'hf04f, 16'h0000, 1'b1, 1'b0);
        for (int j = 0; j < 128; j++) begin
            r = $random(seed);
            apply({5'h1e, r[10], 1'b0, j[4:0], j[5] ? 4'hf : r[3:0]},
                {1'b0, r[30:28], j[6] ? 4'hf : r[27:24], r[23:16]}, r[31], 1'b0);
        end
        for (int j = 0; j < 4000; j++) begin
            r = $random(seed);
            apply(r[15:0], r[31:16], j[0], j[9:0] == 10'h200);
        end
        for (int n = 0; n < 4 && exp_q.size() > 0; n++) @(negedge i_ref_clk);
        if (exp_q.size() > 0) num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
